// ==== prog_port_pkg.sv ====
// Constants and types for the synthesizer serial programming port
package prog_port_pkg;
  localparam int WORD_BITS = 16;
  localparam int ADDR_BITS = 4;
  localparam int DATA_BITS = 12;
  localparam int DIVIDER_BITS = 9;
  localparam int DIVIDEND_HI_BITS = 10;
  localparam int DIVIDEND_LO_BITS = 8;
  localparam int DIVIDEND_BITS = 18;
  localparam int MOD_BITS = 12;
  localparam int SHIFT_BITS = 4;
  localparam int SHORT_MIN = 2;
  localparam int SHORT_MAX = 12;
  localparam int COUNT_BITS = 5;
  // Register addresses
  localparam logic [3:0] ADDR_DIVIDER = 4'h0;
  localparam logic [3:0] ADDR_DIVIDEND_HI = 4'h1;
  localparam logic [3:0] ADDR_DIVIDEND_LO = 4'h2;
  localparam logic [3:0] ADDR_REF_DIV = 4'h5;
  localparam logic [3:0] ADDR_PD_CTRL = 4'h6;
  localparam logic [3:0] ADDR_PWR_MUX = 4'h7;
  localparam logic [3:0] ADDR_MOD_CTRL = 4'h8;
  localparam logic [3:0] ADDR_MOD_DATA = 4'h9;
  // Reset values
  localparam logic [8:0] DIVIDER_RESET = 9'h006;
  localparam logic [11:0] REG_RESET = 12'h000;
  // Integer offset added to the divider value
  localparam logic [9:0] RATIO_OFFSET = 10'h020;
  // Field positions
  localparam int MUX_SEL_LSB = 6;
  localparam int MUX_SEL_BITS = 3;
  localparam int MODE_INT_BIT = 9;
  localparam int MODE_18_BIT = 10;
  localparam int MOD_SRC_BIT = 4;
  localparam logic [2:0] MUX_SERIAL = 3'h5;
  typedef enum logic [1:0] {MODE_INTEGER, MODE_FRAC10, MODE_FRAC18} ratio_mode_t;
endpackage : prog_port_pkg

// ==== word_path_if.sv ====
// Carrier for received serial words between capture and buffer
`timescale 1ns/1ps
`default_nettype none
interface word_path_if;
  logic in_valid;
  logic in_ready;
  logic [15:0] in_word;
  logic [4:0] in_len;
  logic out_valid;
  logic out_ready;
  logic [15:0] out_word;
  logic [4:0] out_len;
  modport buf_side (input in_valid, in_word, in_len, out_ready, output in_ready, out_valid, out_word, out_len);
  modport user_side (output in_valid, in_word, in_len, out_ready, input in_ready, out_valid, out_word, out_len);
endinterface : word_path_if
`default_nettype wire

// ==== word_buffer.sv ====
// Two-entry buffer for captured serial words
`timescale 1ns/1ps
`default_nettype none
module word_buffer #(
  parameter int DEPTH = 2
) (
  input wire logic mclk,
  input wire logic rst,
  word_path_if.buf_side path
);
  logic [15:0] word_mem [DEPTH];
  logic [4:0] len_mem [DEPTH];
  logic [$clog2(DEPTH)-1:0] wr_ptr;
  logic [$clog2(DEPTH)-1:0] rd_ptr;
  logic [$clog2(DEPTH):0] fill;
  wire push = path.in_valid && path.in_ready;
  wire pop = path.out_valid && path.out_ready;
  assign path.in_ready = (fill != DEPTH[$clog2(DEPTH):0]);
  assign path.out_valid = (fill != '0);
  assign path.out_word = word_mem[rd_ptr];
  assign path.out_len = len_mem[rd_ptr];
  always_ff @(posedge mclk) begin
    if (push) begin
      word_mem[wr_ptr] <= path.in_word;
      len_mem[wr_ptr] <= path.in_len;
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
      fill <= fill + {{$clog2(DEPTH){1'b0}}, push} - {{$clog2(DEPTH){1'b0}}, pop};
    end
  end
endmodule : word_buffer
`default_nettype wire

// ==== synth_serial_program_port.sv ====
// Serial programming port of the fractional-N synthesizer
`timescale 1ns/1ps
`default_nettype none
module synth_serial_program_port #(
  parameter int BUF_DEPTH = 2
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic ser_cs_n,
  input wire logic mod_in,
  input wire logic phase_compare_clock,
  input wire logic ref_osc,
  input wire logic ref_div_clk,
  output logic mux_out,
  output logic [1:0] ratio_mode,
  output logic [9:0] ratio_int,
  output logic [17:0] ratio_frac,
  output logic ratio_update,
  output logic [4:0] ref_div_index,
  output logic [11:0] pd_ctrl,
  output logic [11:0] pwr_mux_ctrl,
  output logic [11:0] mod_ctrl,
  output logic [17:0] mod_value,
  output logic mod_strobe
);
  // Two-stage synchronisers; first stage feeds only the second
  logic [4:0] sync_a;
  logic [4:0] sync_b;
  logic sclk_last;
  logic pdclk_last;
  // Idle levels: clocks low, chip select high, so no false edge follows reset
  localparam logic [4:0] SYNC_IDLE = 5'h04;
  always_ff @(posedge mclk) begin
    if (rst) begin
      sync_a <= SYNC_IDLE;
      sync_b <= SYNC_IDLE;
    end else begin
      sync_a <= {phase_compare_clock, mod_in, ser_cs_n, ser_data, ser_clk};
      sync_b <= sync_a;
    end
  end
  wire sclk_s = sync_b[0];
  wire data_s = sync_b[1];
  wire cs_n_s = sync_b[2];
  wire modin_s = sync_b[3];
  wire pdclk_s = sync_b[4];
  wire sclk_rise = sclk_s && !sclk_last;
  wire sclk_fall = !sclk_s && sclk_last;
  wire pdclk_fall = !pdclk_s && pdclk_last;

  // Write-only register file
  logic [8:0] divider;
  logic [9:0] dividend_hi;
  logic [7:0] dividend_lo;
  logic [11:0] ref_div_reg;
  logic [11:0] pd_reg;
  logic [11:0] pwr_reg;
  logic [11:0] modctl_reg;
  logic [11:0] moddata_reg;
  logic moddata_len_short;
  logic [3:0] moddata_len;
  logic mod_pending;

  // Shift capture
  logic [15:0] shreg;
  logic [15:0] modsh;
  logic [4:0] bit_count;
  logic in_frame;
  logic [15:0] echo_sh;

  word_path_if path ();
  word_buffer #(.DEPTH(BUF_DEPTH)) u_buf (
    .mclk(mclk),
    .rst(rst),
    .path(path.buf_side)
  );

  wire use_mod_pin = modctl_reg[prog_port_pkg::MOD_SRC_BIT];
  wire frame_end = in_frame && cs_n_s;
  wire [4:0] bits_max = 5'(prog_port_pkg::WORD_BITS);

  // Frame length classes, decoded at capture and again at drain
  function automatic logic len_is_word(input logic [4:0] len);
    len_is_word = (len == 5'(prog_port_pkg::WORD_BITS));
  endfunction : len_is_word

  function automatic logic len_is_sample(input logic [4:0] len);
    len_is_sample = (len >= 5'(prog_port_pkg::SHORT_MIN)) && (len <= 5'(prog_port_pkg::SHORT_MAX));
  endfunction : len_is_sample

  wire is_full = len_is_word(bit_count);
  wire is_short = len_is_sample(bit_count);
  wire [15:0] frame_word = (is_short && use_mod_pin) ? modsh : shreg;
  assign path.in_valid = frame_end && (is_full || is_short);
  assign path.in_word = frame_word;
  assign path.in_len = bit_count;

  always_ff @(posedge mclk) begin
    if (rst) begin
      sclk_last <= 1'b0;
      pdclk_last <= 1'b0;
      shreg <= '0;
      modsh <= '0;
      bit_count <= '0;
      in_frame <= 1'b0;
    end else begin
      sclk_last <= sclk_s;
      pdclk_last <= pdclk_s;
      // frame opens on chip select low
      if (!cs_n_s && !in_frame) begin
        in_frame <= 1'b1;
        bit_count <= '0;
      end else if (frame_end && (path.in_ready || !path.in_valid)) begin
        // A full buffer keeps the frame open, so the word waits rather than drops
        in_frame <= 1'b0;
      end
      if (!cs_n_s && sclk_rise) begin
        shreg <= {shreg[14:0], data_s};
        modsh <= {modsh[14:0], modin_s};
        if (!in_frame) begin
          bit_count <= 5'h01;
        end else if (bit_count != bits_max) begin
          bit_count <= bit_count + 5'h01;
        end
      end
    end
  end

  // Other mux sources are not modelled here, so they read as low
  wire echo_on = (pwr_reg[prog_port_pkg::MUX_SEL_LSB +: prog_port_pkg::MUX_SEL_BITS] == prog_port_pkg::MUX_SERIAL);
  // echo one bit per falling clock
  always_ff @(posedge mclk) begin
    if (rst) begin
      echo_sh <= '0;
      mux_out <= 1'b0;
    end else begin
      if (!cs_n_s && sclk_rise) echo_sh <= {shreg[14:0], data_s};
      if (!echo_on) begin
        mux_out <= 1'b0;
      end else if (!cs_n_s && sclk_fall) begin
        mux_out <= echo_sh[0];
      end
    end
  end

  // Word decode on the drained side; the register file always accepts
  assign path.out_ready = 1'b1;
  wire take = path.out_valid;
  wire [3:0] waddr = path.out_word[15:12];
  wire [11:0] wdata = path.out_word[11:0];
  wire word_full = len_is_word(path.out_len);
  wire word_short = len_is_sample(path.out_len);

  function automatic logic hits(input logic [3:0] a, input logic [3:0] target);
    hits = take && word_full && (a == target);
  endfunction : hits

  wire wr_divider = hits(waddr, prog_port_pkg::ADDR_DIVIDER);
  wire wr_hi = hits(waddr, prog_port_pkg::ADDR_DIVIDEND_HI);
  wire wr_lo = hits(waddr, prog_port_pkg::ADDR_DIVIDEND_LO);
  wire wr_moddata = hits(waddr, prog_port_pkg::ADDR_MOD_DATA);
  wire wr_short = take && word_short;
  wire wr_ref_div = hits(waddr, prog_port_pkg::ADDR_REF_DIV);
  wire wr_pd = hits(waddr, prog_port_pkg::ADDR_PD_CTRL);
  wire wr_pwr = hits(waddr, prog_port_pkg::ADDR_PWR_MUX);
  wire wr_modctl = hits(waddr, prog_port_pkg::ADDR_MOD_CTRL);

  prog_port_pkg::ratio_mode_t mode_now;
  assign mode_now = pwr_reg[prog_port_pkg::MODE_INT_BIT] ? prog_port_pkg::MODE_INTEGER :
                    pwr_reg[prog_port_pkg::MODE_18_BIT] ? prog_port_pkg::MODE_FRAC18 :
                    prog_port_pkg::MODE_FRAC10;

  // reset values, divider starts at six
  always_ff @(posedge mclk) begin
    if (rst) begin
      divider <= prog_port_pkg::DIVIDER_RESET;
      dividend_hi <= '0;
      dividend_lo <= '0;
    end else begin
      if (wr_divider) divider <= wdata[8:0];
      if (wr_hi) dividend_hi <= wdata[9:0];
      if (wr_lo) dividend_lo <= wdata[7:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      ref_div_reg <= prog_port_pkg::REG_RESET;
      pd_reg <= prog_port_pkg::REG_RESET;
      pwr_reg <= prog_port_pkg::REG_RESET;
      modctl_reg <= prog_port_pkg::REG_RESET;
    end else begin
      if (wr_ref_div) ref_div_reg <= wdata;
      if (wr_pd) pd_reg <= wdata;
      if (wr_pwr) pwr_reg <= wdata;
      if (wr_modctl) modctl_reg <= wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      moddata_reg <= prog_port_pkg::REG_RESET;
      moddata_len <= '0;
      moddata_len_short <= 1'b0;
    end else begin
      if (wr_moddata) begin
        moddata_reg <= wdata;
        moddata_len_short <= 1'b0;
      end else if (wr_short) begin
        moddata_reg <= path.out_word[11:0];
        moddata_len <= path.out_len[3:0];
        moddata_len_short <= 1'b1;
      end
    end
  end

  // Sign-extend a short sample from its own length before scaling
  // Lift the sample's top bit to bit 17, then shift back arithmetically
  wire [4:0] short_up = 5'(prog_port_pkg::MOD_BITS) - {1'b0, moddata_len};
  wire [4:0] short_down = 5'(prog_port_pkg::DIVIDEND_BITS) - {1'b0, moddata_len};
  wire [17:0] short_top = 18'({moddata_reg, 6'h00} << short_up);
  logic [17:0] mod_ext;
  always_comb begin
    mod_ext = {{6{moddata_reg[11]}}, moddata_reg};
    if (moddata_len_short && moddata_len != 4'h0) begin
      mod_ext = 18'($signed(short_top) >>> short_down);
    end
  end
  wire [3:0] mag_shift = modctl_reg[3:0];
  wire [17:0] mod_scaled = 18'(mod_ext << mag_shift);

  // ratio composition: integer part plus signed dividend
  wire [9:0] int_part = {1'b0, divider} + prog_port_pkg::RATIO_OFFSET;
  wire [9:0] int_new = {1'b0, wdata[8:0]} + prog_port_pkg::RATIO_OFFSET;
  // eighteen-bit dividend kept two's complement across both registers
  wire [17:0] frac18 = {wdata[9:0], dividend_lo};
  // ten-bit dividend sign-extended to full width
  wire [17:0] frac10 = {{8{wdata[9]}}, wdata[9:0]};

  always_ff @(posedge mclk) begin
    if (rst) begin
      ratio_mode <= 2'(prog_port_pkg::MODE_INTEGER);
      ratio_int <= {1'b0, prog_port_pkg::DIVIDER_RESET} + prog_port_pkg::RATIO_OFFSET;
      ratio_frac <= '0;
      ratio_update <= 1'b0;
    end else begin
      ratio_update <= 1'b0;
      case (mode_now)
        prog_port_pkg::MODE_INTEGER: begin
          if (wr_divider) begin
            ratio_int <= int_new;
            ratio_frac <= '0;
            ratio_mode <= 2'(prog_port_pkg::MODE_INTEGER);
            ratio_update <= 1'b1;
          end
        end
        prog_port_pkg::MODE_FRAC18: begin
          if (wr_hi) begin
            ratio_int <= int_part;
            ratio_frac <= frac18;
            ratio_mode <= 2'(prog_port_pkg::MODE_FRAC18);
            ratio_update <= 1'b1;
          end
        end
        prog_port_pkg::MODE_FRAC10: begin
          if (wr_hi) begin
            ratio_int <= int_part;
            ratio_frac <= frac10;
            ratio_mode <= 2'(prog_port_pkg::MODE_FRAC10);
            ratio_update <= 1'b1;
          end
        end
        default: ratio_update <= 1'b0;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      mod_pending <= 1'b0;
      mod_value <= '0;
      mod_strobe <= 1'b0;
    end else begin
      mod_strobe <= 1'b0;
      // Only a written sample moves the output; a control write alone waits for data
      if (pdclk_fall && mod_pending) begin
        mod_value <= mod_scaled;
        mod_strobe <= 1'b1;
      end
      // A write landing with a phase fall is forwarded at the following fall
      if (wr_moddata || wr_short) begin
        mod_pending <= 1'b1;
      end else if (pdclk_fall) begin
        mod_pending <= 1'b0;
      end
    end
  end

  assign ref_div_index = ref_div_reg[4:0];
  assign pd_ctrl = pd_reg;
  assign pwr_mux_ctrl = pwr_reg;
  assign mod_ctrl = modctl_reg;
  wire unused = ^{ref_osc, ref_div_clk};
endmodule : synth_serial_program_port
`default_nettype wire

// ==== synth_port_properties.sv ====
// Concurrent checks on the serial programming port outputs
`timescale 1ns/1ps
`default_nettype none
module synth_port_properties (
  input wire logic mclk,
  input wire logic rst,
  input wire logic phase_compare_clock,
  input wire logic mux_out,
  input wire logic [9:0] ratio_int,
  input wire logic [17:0] ratio_frac,
  input wire logic ratio_update,
  input wire logic [11:0] pwr_mux_ctrl,
  input wire logic [11:0] pd_ctrl,
  input wire logic [11:0] mod_ctrl,
  input wire logic [17:0] mod_value,
  input wire logic mod_strobe
);
  wire logic [2:0] sel = pwr_mux_ctrl[8:6];
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  chk_update_one_cycle: assert property (ratio_update |=> !ratio_update)
    else $error("ratio_update longer than one cycle");
  chk_strobe_one_cycle: assert property (mod_strobe |=> !mod_strobe)
    else $error("mod_strobe longer than one cycle");
  chk_strobe_phase_fall: assert property (mod_strobe |-> !phase_compare_clock && $past(phase_compare_clock, 8))
    else $error("mod_strobe not after phase clock fall");
  chk_echo_off_low: assert property (sel != prog_port_pkg::MUX_SERIAL && $past(sel) != prog_port_pkg::MUX_SERIAL |-> !mux_out)
    else $error("mux_out active while not selected");
  chk_reset_value_set: assert property ($fell(rst) |-> ratio_int == 10'h026 && ratio_frac == 18'h00000 && mod_value == 18'h00000 && pd_ctrl == 12'h000 && mod_ctrl == 12'h000)
    else $error("wrong value after reset");
  chk_ratio_int_range: assert property (ratio_int >= 10'h020 && ratio_int <= 10'h21F)
    else $error("ratio_int out of range");
  chk_ratio_change_pulse: assert property (($changed(ratio_int) || $changed(ratio_frac)) && !$past(rst) |-> ##[0:1] ratio_update)
    else $error("ratio changed without ratio_update");
  chk_mod_change_strobe: assert property ($changed(mod_value) && !$past(rst) |-> mod_strobe || $past(mod_strobe))
    else $error("mod_value changed without mod_strobe");
endmodule : synth_port_properties
`default_nettype wire

// ==== serial_master_model.sv ====
// Serial master driving clock, data, chip select and modulation pin
`timescale 1ns/1ps
`default_nettype none
module serial_master_model (
  input wire logic mclk,
  output logic ser_clk,
  output logic ser_data,
  output logic ser_cs_n,
  output logic mod_in
);
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    ser_cs_n = 1'b1;
    mod_in = 1'b1;
  end
  // Clock idles low between frames; idle data lines invert so no stale bit is reused
  task automatic send(input logic [17:0] bits, input int n, input logic alt);
    @(negedge mclk) ser_cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      ser_data = alt ? ~bits[i] : bits[i];
      mod_in = alt ? bits[i] : ~bits[i];
      repeat (4) @(negedge mclk);
      ser_clk = 1'b1;
      repeat (4) @(negedge mclk);
      ser_clk = 1'b0;
    end
    repeat (4) @(negedge mclk);
    ser_cs_n = 1'b1;
    ser_data = ~ser_data;
    mod_in = ~mod_in;
    repeat (12) @(negedge mclk);
  endtask : send
endmodule : serial_master_model
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench for the serial programming port
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) total_checks++; if ((a) !== (e)) begin n_fail++; $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end
module tb_top;
  logic mclk = 1'b0, rst = 1'b1, phase_compare_clock = 1'b0, ref_osc = 1'b0, ref_div_clk = 1'b0;
  logic ser_clk, ser_data, ser_cs_n, mod_in, mux_out, ratio_update, mod_strobe, mux_hi = 1'b0;
  logic [1:0] ratio_mode;
  logic [9:0] ratio_int;
  logic [17:0] ratio_frac, mod_value;
  logic [4:0] ref_div_index;
  logic [11:0] pd_ctrl, pwr_mux_ctrl, mod_ctrl;
  int n_fail = 0, total_checks = 0, n_upd = 0, n_str = 0;
  serial_master_model m (.mclk, .ser_clk, .ser_data, .ser_cs_n, .mod_in);
  synth_serial_program_port dut (.mclk, .rst, .ser_clk, .ser_data, .ser_cs_n, .mod_in, .phase_compare_clock,
    .ref_osc, .ref_div_clk, .mux_out, .ratio_mode, .ratio_int, .ratio_frac, .ratio_update, .ref_div_index,
    .pd_ctrl, .pwr_mux_ctrl, .mod_ctrl, .mod_value, .mod_strobe);
  initial forever #20 mclk = ~mclk;
  initial forever begin
    repeat (30) @(negedge mclk);
    phase_compare_clock = ~phase_compare_clock;
  end
  always @(posedge mclk) begin
    if (ratio_update === 1'b1) n_upd++;
    if (mod_strobe === 1'b1) n_str++;
    if (mux_out === 1'b1) mux_hi <= 1'b1;
  end
  task wr(input logic [3:0] a, input logic [11:0] d);
    m.send({2'b00, a, d}, 16, 1'b0);
  endtask : wr
  task ms(input logic [17:0] b, input int n, input logic alt, input logic [17:0] e);
    int s;
    s = n_str;
    m.send(b, n, alt);
    for (int k = 0; k < 200 && n_str == s; k++) @(negedge mclk);
    `CHK("mod_value", e, mod_value)
  endtask : ms
  task t_reset;
    `CHK("ratio_int", 10'h026, ratio_int)
    `CHK("pwr_mux", 12'h000, pwr_mux_ctrl)
    $display("test reset done");
  endtask : t_reset
  task t_ctrl;
    m.send(18'h16ABC, 17, 1'b0);
    wr(4'h5, 12'h01F);
    `CHK("pd_ctrl", 12'hABC, pd_ctrl)
    `CHK("ref_div", 5'h1F, ref_div_index)
    wr(4'h3, 12'h123);
    m.send(18'h00555, 14, 1'b0);
    `CHK("pd_ctrl", 12'hABC, pd_ctrl)
    `CHK("ref_div", 5'h1F, ref_div_index)
    $display("test control done");
  endtask : t_ctrl
  task t_int;
    int u;
    wr(4'h7, 12'h340);
    u = n_upd;
    wr(4'h0, 12'h1FF);
    `CHK("ratio_int", 10'h21F, ratio_int)
    `CHK("mode", prog_port_pkg::MODE_INTEGER, ratio_mode)
    `CHK("updates", u + 1, n_upd)
    `CHK("echo", 1'b1, mux_hi)
    `CHK("echo_last", 1'b1, mux_out)
    $display("test integer done");
  endtask : t_int
  task t_f18;
    int u;
    wr(4'h7, 12'h400);
    `CHK("echo_off", 1'b0, mux_out)
    u = n_upd;
    wr(4'h0, 12'h00D);
    wr(4'h2, 12'h098);
    `CHK("updates", u, n_upd)
    wr(4'h1, 12'h07D);
    `CHK("ratio_int", 10'h02D, ratio_int)
    `CHK("ratio_frac", 18'h07D98, ratio_frac)
    `CHK("mode", prog_port_pkg::MODE_FRAC18, ratio_mode)
    `CHK("updates", u + 1, n_upd)
    $display("test frac18 done");
  endtask : t_f18
  task t_f10;
    wr(4'h7, 12'h000);
    wr(4'h0, 12'h010);
    wr(4'h1, 12'h334);
    `CHK("ratio_int", 10'h030, ratio_int)
    `CHK("ratio_frac", 18'h3FF34, ratio_frac)
    `CHK("mode", prog_port_pkg::MODE_FRAC10, ratio_mode)
    $display("test frac10 done");
  endtask : t_f10
  task t_mod;
    int s;
    wr(4'h8, 12'h001);
    ms(18'h0000A, 4, 1'b0, 18'h3FFF4);
    wr(4'h8, 12'h010);
    `CHK("mod_ctrl", 12'h010, mod_ctrl)
    ms(18'h00003, 3, 1'b1, 18'h00003);
    s = n_str;
    m.send(18'h00001, 1, 1'b0);
    m.send(18'h01555, 13, 1'b0);
    repeat (150) @(negedge mclk);
    `CHK("strobes", s, n_str)
    `CHK("mod_value", 18'h00003, mod_value)
    ms({6'h09, 12'h7FF}, 16, 1'b0, 18'h007FF);
    $display("test modulation done");
  endtask : t_mod
  task stop_test;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test
  // Expected run is well under a quarter of this span
  initial begin
    #1000000;
    n_fail++;
    stop_test;
  end
  initial begin
    repeat (3) @(negedge mclk);
    rst = 1'b0;
    repeat (4) @(negedge mclk);
    t_reset;
    t_ctrl;
    t_int;
    t_f18;
    t_f10;
    t_mod;
    stop_test;
  end
endmodule : tb_top
bind synth_serial_program_port synth_port_properties chk (.mclk, .rst, .phase_compare_clock, .mux_out, .ratio_int,
  .ratio_frac, .ratio_update, .pwr_mux_ctrl, .pd_ctrl, .mod_ctrl, .mod_value, .mod_strobe);
`default_nettype wire
